// ---- hdl/sctp_top.sv ----
`timescale 1ns/1ps
// Summary of operation
// - Missing handshake lines read as always ready
// - Output: translate, then parity, then shorten
// - Input: expand, then parity, then translate
// - Each stage works on prior stage result
// - Appended LF also gets parity and shortening
// - One mode for both directions; none passes
// - Line end becomes CR out, CR becomes line end in
// - Append gives CR then LF
// - Translation clears top bit both ways
// - Light input: clear top, CR to line end
// - Light output: line end to CR, clear top
// - Translation mode resets to light
// - Heavy input: out of range gets substitute
// - Substitute per port, resets to zero
// - Heavy output drops unprintable characters
// - LF after every CR, translation only, off
// - Separate parity modes, parity is bit 7
// - Default parity leaves bit 7 alone
// - Output parity: even, odd, mark, keep
// - Input parity: keep, even, odd, nocheck
// - Parity error delivers char, sets flag
// - Line states readable unless continuous transfer
// - Shortening keeps low bits of word
// - Expansion fills added bits with ones
// - Settings held separately per port
module sctp_top #(
    parameter int         NPORT   = 4,
    parameter logic [3:0] HAS_DSR = 4'h7,
    parameter logic [3:0] HAS_CTS = 4'h1,
    parameter logic [3:0] HAS_CD  = 4'h1
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        host_tx_valid,
    input  wire logic [1:0]  host_tx_port,
    input  wire logic [7:0]  host_tx_char,
    output logic             host_tx_ready,
    output logic             ser_tx_valid,
    output logic      [1:0]  ser_tx_port,
    output logic      [7:0]  ser_tx_word,
    input  wire logic        ser_tx_ready,
    input  wire logic        ser_rx_valid,
    input  wire logic [1:0]  ser_rx_port,
    input  wire logic [7:0]  ser_rx_word,
    output logic             host_rx_valid,
    output logic      [1:0]  host_rx_port,
    output logic      [7:0]  host_rx_char,
    output logic             host_rx_perr,
    input  wire logic [3:0]  dsr_input,
    input  wire logic [3:0]  cts_input,
    input  wire logic [3:0]  carrier_detect_input,
    output logic      [3:0]  lines_ok
);
    if (NPORT != 4) begin : g_chk
        $error("sctp_top serves exactly four ports");
    end

    // Shorten to word size, upper bits zero
    function automatic logic [7:0] shorten(input logic [1:0] ws, input logic [7:0] c);
        case (ws)
            sctp_pkg::WS_7: shorten = {1'b0, c[6:0]};
            sctp_pkg::WS_6: shorten = {2'b00, c[5:0]};
            sctp_pkg::WS_5: shorten = {3'b000, c[4:0]};
            default:        shorten = c;
        endcase
    endfunction : shorten

    // Expand short word, added bits set
    function automatic logic [7:0] expand(input logic [1:0] ws, input logic [7:0] w);
        case (ws)
            sctp_pkg::WS_7: expand = {1'b1, w[6:0]};
            sctp_pkg::WS_6: expand = {2'b11, w[5:0]};
            sctp_pkg::WS_5: expand = {3'b111, w[4:0]};
            default:        expand = w;
        endcase
    endfunction : expand

    // Output parity on bit 7
    function automatic logic [7:0] par_out(input logic [1:0] m, input logic [7:0] c);
        case (m)
            sctp_pkg::OP_EVEN: par_out = {^c[6:0], c[6:0]};
            sctp_pkg::OP_ODD:  par_out = {~^c[6:0], c[6:0]};
            sctp_pkg::OP_MARK: par_out = {1'b1, c[6:0]};
            default:           par_out = c;
        endcase
    endfunction : par_out

    // Output translation: {drop, add_lf, char}
    function automatic logic [9:0] xl_out(input logic [1:0] m, input logic ap, input logic [7:0] c);
        logic [7:0] ch;
        logic       drop;
        ch   = (c == sctp_pkg::LINE_END_CODE) ? sctp_pkg::CODE_CR : c;
        drop = 1'b0;
        if (m == sctp_pkg::XL_HEAVY && c != sctp_pkg::LINE_END_CODE &&
            (c < sctp_pkg::CODE_LOW || c > sctp_pkg::CODE_HIGH)) begin
            drop = 1'b1;
        end
        ch[7] = 1'b0;
        if (m == sctp_pkg::XL_LIGHT || m == sctp_pkg::XL_HEAVY) begin
            xl_out = {drop, ap && ch == sctp_pkg::CODE_CR && !drop, ch};
        end else begin
            xl_out = {2'b00, c};
        end
    endfunction : xl_out

    // Input translation
    function automatic logic [7:0] xl_in(input logic [1:0] m, input logic [7:0] sub, input logic [7:0] w);
        logic [7:0] ch;
        ch = {1'b0, w[6:0]};
        if (m == sctp_pkg::XL_LIGHT || m == sctp_pkg::XL_HEAVY) begin
            if (ch == sctp_pkg::CODE_CR) begin
                xl_in = sctp_pkg::LINE_END_CODE;
            end else if (m == sctp_pkg::XL_HEAVY &&
                         (ch < sctp_pkg::CODE_LOW || ch > sctp_pkg::CODE_HIGH)) begin
                xl_in = sub;
            end else begin
                xl_in = ch;
            end
        end else begin
            xl_in = w;
        end
    endfunction : xl_in

    // Per-port settings and errors, shared control and sequencer state
    logic [sctp_pkg::CFG_W-1:0] cfg_q [NPORT];
    logic [NPORT-1:0]           perr_q;
    logic                       cont_q;
    logic [11:0]                hs_meta_q;
    logic [11:0]                hs_q;
    sctp_pkg::sctp_state_type   state_q;
    logic [7:0]                 lf_word_q;
    logic                       lf_pend_q;

    // APB decode
    wire        apb_acc   = psel && penable && pready;
    wire        apb_wr    = apb_acc && pwrite;
    wire [1:0]  a_idx     = paddr[3:2];
    wire        hit_cfg   = paddr[7:4] == sctp_pkg::ADDR_CFG0[7:4] && paddr[1:0] == 2'b00;
    wire        hit_stat  = paddr[7:4] == sctp_pkg::ADDR_STAT0[7:4] && paddr[1:0] == 2'b00;
    wire        hit_ctrl  = paddr == sctp_pkg::ADDR_CTRL;
    wire        stat_busy = hit_stat && cont_q && !pwrite;
    wire        bad_addr  = !(hit_cfg || hit_stat || hit_ctrl) || stat_busy;

    // Handshake lines, absent ones forced ready
    wire [3:0] dsr_now = hs_q[3:0] | ~HAS_DSR;
    wire [3:0] cts_now = hs_q[7:4] | ~HAS_CTS;
    wire [3:0] cd_now  = hs_q[11:8] | ~HAS_CD;

    wire [31:0] stat_word = {25'h0, cd_now[a_idx], cts_now[a_idx], dsr_now[a_idx],
                             3'h0, perr_q[a_idx]};
    wire [31:0] rd_word = hit_cfg  ? {8'h0, cfg_q[a_idx]} :
                          hit_stat ? stat_word : {31'h0, cont_q};

    // Bus answer, one wait state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0;
        end else begin
            pready  <= psel && penable && !pready;
            pslverr <= psel && penable && !pready && bad_addr;
            prdata  <= (psel && penable && !pready && !bad_addr && !pwrite) ? rd_word : 32'h0;
        end
    end

    // Config writes, light mode and zero substitute at reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < NPORT; i++) cfg_q[i] <= sctp_pkg::CFG_RST;
            cont_q <= 1'b0;
        end else if (apb_wr && !bad_addr) begin
            if (hit_cfg) cfg_q[a_idx] <= pwdata[sctp_pkg::CFG_W-1:0];
            if (hit_ctrl) cont_q <= pwdata[0];
        end
    end

    // Handshake synchroniser
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hs_meta_q <= 12'h0;
            hs_q      <= 12'h0;
        end else begin
            hs_meta_q <= {carrier_detect_input, cts_input, dsr_input};
            hs_q      <= hs_meta_q;
        end
    end

    // Line check summary per port
    logic [3:0] ok_d;
    always_comb begin
        for (int i = 0; i < NPORT; i++) begin
            ok_d[i] = (dsr_now[i] || !cfg_q[i][sctp_pkg::CHK_LSB]) &&
                      (cts_now[i] || !cfg_q[i][sctp_pkg::CHK_LSB+1]) &&
                      (cd_now[i]  || !cfg_q[i][sctp_pkg::CHK_LSB+2]);
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) lines_ok <= 4'h0;
        else          lines_ok <= ok_d;
    end

    // Output chain for the requested port
    wire [23:0] tcfg   = cfg_q[host_tx_port];
    wire [1:0]  t_xl   = tcfg[sctp_pkg::XL_LSB+:2];
    wire [1:0]  t_par  = tcfg[sctp_pkg::OPAR_LSB+:2];
    wire [1:0]  t_ws   = tcfg[sctp_pkg::WSZ_LSB+:2];
    wire [9:0]  t_x    = xl_out(t_xl, tcfg[sctp_pkg::APLF_BIT], host_tx_char);
    wire [7:0]  t_word = shorten(t_ws, par_out(t_par, t_x[7:0]));
    wire [7:0]  t_lf   = shorten(t_ws, par_out(t_par, sctp_pkg::CODE_LF));
    wire        tx_acc = host_tx_valid && host_tx_ready;
    wire        out_go = ser_tx_valid && ser_tx_ready;

    // Output sequencer
    sctp_pkg::sctp_state_type state_d;
    always_comb begin
        state_d = state_q;
        case (state_q)
            sctp_pkg::ST_IDLE: if (tx_acc && !t_x[9]) state_d = sctp_pkg::ST_CHAR;
            sctp_pkg::ST_CHAR: begin
                if (out_go && lf_pend_q) state_d = sctp_pkg::ST_LF;
                else if (out_go)         state_d = sctp_pkg::ST_IDLE;
            end
            sctp_pkg::ST_LF:   if (out_go) state_d = sctp_pkg::ST_IDLE;
            default:           state_d = sctp_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q       <= sctp_pkg::ST_IDLE;
            host_tx_ready <= 1'b0;
            ser_tx_valid  <= 1'b0;
            ser_tx_port   <= 2'h0;
            ser_tx_word   <= 8'h0;
            lf_word_q     <= 8'h0;
            lf_pend_q     <= 1'b0;
        end else begin
            state_q       <= state_d;
            host_tx_ready <= state_d == sctp_pkg::ST_IDLE;
            ser_tx_valid  <= state_d != sctp_pkg::ST_IDLE;
            if (state_q == sctp_pkg::ST_IDLE && tx_acc) begin
                ser_tx_port <= host_tx_port;
                ser_tx_word <= t_word;
                lf_word_q   <= t_lf;
                lf_pend_q   <= t_x[8];
            end else if (state_q == sctp_pkg::ST_CHAR && out_go) begin
                ser_tx_word <= lf_word_q;
                lf_pend_q   <= 1'b0;
            end
        end
    end

    // Input chain for the receiving port
    wire [23:0] rcfg  = cfg_q[ser_rx_port];
    wire [1:0]  r_ip  = rcfg[sctp_pkg::IPAR_LSB+:2];
    wire [7:0]  r_exp = expand(rcfg[sctp_pkg::WSZ_LSB+:2], ser_rx_word);
    wire        r_bad = (r_ip == sctp_pkg::IP_EVEN && ^r_exp) ||
                        (r_ip == sctp_pkg::IP_ODD && !(^r_exp));
    wire [7:0]  r_par = (r_ip == sctp_pkg::IP_KEEP) ? r_exp : {1'b0, r_exp[6:0]};
    wire [7:0]  r_chr = xl_in(rcfg[sctp_pkg::XL_LSB+:2], rcfg[sctp_pkg::SUB_LSB+:8], r_par);

    // Delivered character, error flag beside it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            host_rx_valid <= 1'b0;
            host_rx_port  <= 2'h0;
            host_rx_char  <= 8'h0;
            host_rx_perr  <= 1'b0;
        end else begin
            host_rx_valid <= ser_rx_valid;
            host_rx_port  <= ser_rx_port;
            host_rx_char  <= r_chr;
            host_rx_perr  <= ser_rx_valid && r_bad;
        end
    end

    // Sticky parity error, set beats write-one-clear
    logic [3:0] perr_clr;
    logic [3:0] perr_set;
    always_comb begin
        for (int i = 0; i < NPORT; i++) begin
            perr_clr[i] = apb_wr && hit_stat && a_idx == i[1:0] && pwdata[sctp_pkg::ST_PERR_BIT];
            perr_set[i] = ser_rx_valid && r_bad && ser_rx_port == i[1:0];
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) perr_q <= 4'h0;
        else          perr_q <= (perr_q & ~perr_clr) | perr_set;
    end

    // Checks
    property p_drop;
        @(posedge pclk) disable iff (!presetn)
        (tx_acc && t_x[9]) |=> (state_q == sctp_pkg::ST_IDLE) && !ser_tx_valid;
    endproperty
    a_drop: assert property (p_drop) else $error("dropped char emitted");

    property p_lf;
        @(posedge pclk) disable iff (!presetn)
        (out_go && state_q == sctp_pkg::ST_CHAR && lf_pend_q) |=> ser_tx_valid && ser_tx_word == $past(lf_word_q);
    endproperty
    a_lf: assert property (p_lf) else $error("LF missing after CR");

    property p_cr;
        @(posedge pclk) disable iff (!presetn)
        (tx_acc && host_tx_char == sctp_pkg::LINE_END_CODE && t_xl != sctp_pkg::XL_NONE &&
         t_par == sctp_pkg::OP_KEEP && t_ws == sctp_pkg::WS_8) |=> ser_tx_word == sctp_pkg::CODE_CR;
    endproperty
    a_cr: assert property (p_cr) else $error("line end not sent as CR");

    property p_nolf;
        @(posedge pclk) disable iff (!presetn)
        (tx_acc && t_xl == sctp_pkg::XL_NONE) |=> !lf_pend_q;
    endproperty
    a_nolf: assert property (p_nolf) else $error("LF without translation");

    property p_perr;
        @(posedge pclk) disable iff (!presetn)
        (ser_rx_valid && r_bad) |=> host_rx_valid && host_rx_perr && perr_q[$past(ser_rx_port)];
    endproperty
    a_perr: assert property (p_perr) else $error("parity error not flagged");

    property p_strip;
        @(posedge pclk) disable iff (!presetn)
        (ser_rx_valid && r_ip != sctp_pkg::IP_KEEP && rcfg[1:0] == sctp_pkg::XL_NONE) |=> !host_rx_char[7];
    endproperty
    a_strip: assert property (p_strip) else $error("bit 7 not cleared");

    property p_heavy;
        @(posedge pclk) disable iff (!presetn)
        (ser_rx_valid && rcfg[1:0] == sctp_pkg::XL_HEAVY) |=>
            host_rx_char == sctp_pkg::LINE_END_CODE || host_rx_char == $past(rcfg[23:16]) ||
            (host_rx_char >= sctp_pkg::CODE_LOW && host_rx_char <= sctp_pkg::CODE_HIGH);
    endproperty
    a_heavy: assert property (p_heavy) else $error("heavy input out of range");

    property p_short;
        @(posedge pclk) disable iff (!presetn)
        ser_tx_valid && cfg_q[ser_tx_port][9:8] == sctp_pkg::WS_5 |-> ser_tx_word[7:5] == 3'h0;
    endproperty
    a_short: assert property (p_short) else $error("short word has high bits");

    property p_absent;
        @(posedge pclk) disable iff (!presetn)
        (!HAS_DSR[3] && !HAS_CTS[3] && !HAS_CD[3] && $past(presetn)) |=> lines_ok[3];
    endproperty
    a_absent: assert property (p_absent) else $error("absent line not ready");

    property p_expand;
        @(posedge pclk) disable iff (!presetn)
        (ser_rx_valid && rcfg[1:0] >= sctp_pkg::XL_NONE &&
         (rcfg[9:8] == sctp_pkg::WS_6 || rcfg[9:8] == sctp_pkg::WS_5)) |=> host_rx_char[6];
    endproperty
    a_expand: assert property (p_expand) else $error("expanded bit not set");

    c_drop:  cover property (@(posedge pclk) disable iff (!presetn) tx_acc && t_x[9]);
    c_crlf:  cover property (@(posedge pclk) disable iff (!presetn) state_q == sctp_pkg::ST_LF && out_go);
    c_perr:  cover property (@(posedge pclk) disable iff (!presetn) host_rx_perr);
    c_pend:  cover property (@(posedge pclk) disable iff (!presetn) state_q == sctp_pkg::ST_CHAR && lf_pend_q);
    c_stall: cover property (@(posedge pclk) disable iff (!presetn) ser_tx_valid && !ser_tx_ready [*3]);
endmodule : sctp_top

// ---- hdl/sctp_pkg.sv ----
package sctp_pkg;
    // Register byte addresses
    localparam logic [7:0] ADDR_CFG0  = 8'h00;  // Port configs at 0x00..0x0c
    localparam logic [7:0] ADDR_STAT0 = 8'h10;  // Port status at 0x10..0x1c
    localparam logic [7:0] ADDR_CTRL  = 8'h20;

    // Config field positions
    localparam int XL_LSB   = 0;   // [1:0] translation mode
    localparam int IPAR_LSB = 2;   // [3:2] input parity
    localparam int OPAR_LSB = 4;   // [5:4] output parity
    localparam int APLF_BIT = 6;   // Append line feed
    localparam int WSZ_LSB  = 8;   // [9:8] word size
    localparam int CHK_LSB  = 10;  // [12:10] check dsr, cts, carrier
    localparam int SUB_LSB  = 16;  // [23:16] substitute code
    localparam int CFG_W    = 24;
    localparam logic [23:0] CFG_RST = 24'h000000;

    // Status field positions
    localparam int ST_PERR_BIT = 0;
    localparam int ST_DSR_BIT  = 4;
    localparam int ST_CTS_BIT  = 5;
    localparam int ST_CD_BIT   = 6;

    // Translation modes, light is the reset encoding
    localparam logic [1:0] XL_LIGHT = 2'h0;
    localparam logic [1:0] XL_HEAVY = 2'h1;
    localparam logic [1:0] XL_NONE  = 2'h2;

    // Output parity settings
    localparam logic [1:0] OP_KEEP = 2'h0;
    localparam logic [1:0] OP_EVEN = 2'h1;
    localparam logic [1:0] OP_ODD  = 2'h2;
    localparam logic [1:0] OP_MARK = 2'h3;

    // Input parity settings
    localparam logic [1:0] IP_KEEP  = 2'h0;
    localparam logic [1:0] IP_EVEN  = 2'h1;
    localparam logic [1:0] IP_ODD   = 2'h2;
    localparam logic [1:0] IP_NOCHK = 2'h3;

    // Word sizes
    localparam logic [1:0] WS_8 = 2'h0;
    localparam logic [1:0] WS_7 = 2'h1;
    localparam logic [1:0] WS_6 = 2'h2;
    localparam logic [1:0] WS_5 = 2'h3;

    // Character codes
    localparam logic [7:0] CODE_CR       = 8'h0d;
    localparam logic [7:0] CODE_LF       = 8'h0a;
    localparam logic [7:0] LINE_END_CODE = 8'h9b;
    localparam logic [7:0] CODE_LOW      = 8'h20;  // 32, first printable
    localparam logic [7:0] CODE_HIGH     = 8'h7c;  // 124, last printable

    // Output sequencer, Gray coded
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_CHAR = 2'b01,
        ST_LF   = 2'b11
    } sctp_state_type;
endpackage : sctp_pkg

// ---- sim/sctp_serial_model.sv ----
`timescale 1ns/1ps
// Far-side serial device: takes words with stalls, sends words
module sctp_serial_model (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       stall,
    input  wire logic       ser_tx_valid,
    input  wire logic [1:0] ser_tx_port,
    input  wire logic [7:0] ser_tx_word,
    output logic            ser_tx_ready,
    output logic            ser_rx_valid,
    output logic      [1:0] ser_rx_port,
    output logic      [7:0] ser_rx_word
);
    logic [9:0] got_q[$];

    // Idle receive lines
    initial begin
        ser_rx_valid = 1'b0;
        ser_rx_port  = 2'h0;
        ser_rx_word  = 8'h00;
    end

    // Collect words; ready toggles while stalling
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ser_tx_ready <= 1'b0;
        end else begin
            if (ser_tx_valid && ser_tx_ready) got_q.push_back({ser_tx_port, ser_tx_word});
            ser_tx_ready <= stall ? ~ser_tx_ready : 1'b1;
        end
    end

    // One word for one cycle, then the inverse on the data lines
    task automatic put(input logic [1:0] p, input logic [7:0] w);
        @(posedge pclk);
        ser_rx_valid <= 1'b1;
        ser_rx_port  <= p;
        ser_rx_word  <= w;
        @(posedge pclk);
        ser_rx_valid <= 1'b0;
        ser_rx_word  <= ~w;
    endtask : put
endmodule : sctp_serial_model

// ---- sim/serial_char_translate_parity_tb.sv ----
`timescale 1ns/1ps
// Self-checking bench against a queue-based reference
module serial_char_translate_parity_tb;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, stall, er;
    logic        host_tx_valid, host_tx_ready, ser_tx_valid, ser_tx_ready;
    logic        ser_rx_valid, host_rx_valid, host_rx_perr;
    logic [7:0]  paddr, host_tx_char, ser_tx_word, ser_rx_word, host_rx_char;
    logic [31:0] pwdata, prdata, rd;
    logic [1:0]  host_tx_port, ser_tx_port, ser_rx_port, host_rx_port;
    logic [3:0]  dsr_input, cts_input, carrier_detect_input, lines_ok, perr;
    logic [15:0] rng;
    logic [23:0] cfg [4];
    logic [7:0]  chars [10] = '{8'h9b, 8'h0d, 8'h0a, 8'h41, 8'hc1, 8'h7d, 8'h7c, 8'h20, 8'h1f, 8'hff};
    logic [23:0] cfgs [8] = '{24'h0, 24'h44, 24'h3f0059, 24'h42006e, 24'h134, 24'h510239, 24'h31a, 24'h63};
    int          fail_count, check_count;

    sctp_top #(.NPORT(4), .HAS_DSR(4'h7), .HAS_CTS(4'h1), .HAS_CD(4'h1)) dut (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .host_tx_valid, .host_tx_port, .host_tx_char, .host_tx_ready, .ser_tx_valid, .ser_tx_port,
        .ser_tx_word, .ser_tx_ready, .ser_rx_valid, .ser_rx_port, .ser_rx_word, .host_rx_valid,
        .host_rx_port, .host_rx_char, .host_rx_perr, .dsr_input, .cts_input, .carrier_detect_input,
        .lines_ok);
    sctp_serial_model far (.pclk, .presetn, .stall, .ser_tx_valid, .ser_tx_port, .ser_tx_word,
        .ser_tx_ready, .ser_rx_valid, .ser_rx_port, .ser_rx_word);

    // Next value of the 16-bit shift register
    function automatic logic [15:0] lfsr_next(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr_next

    // Clock and pseudo-random stall source
    always #4 pclk = ~pclk;
    always @(posedge pclk) begin
        rng   <= lfsr_next(rng);
        stall <= rng[3];
    end

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            fail_count++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    // One APB transfer; read data and error land in rd and er
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd      = prdata;
        er      = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    function automatic logic [7:0] par(input logic [1:0] op, input logic [7:0] c);
        if (op == sctp_pkg::OP_EVEN) c[7] = ^c[6:0];
        if (op == sctp_pkg::OP_ODD) c[7] = ~^c[6:0];
        if (op == sctp_pkg::OP_MARK) c[7] = 1'b1;
        return c;
    endfunction : par

    // Host character out, serial words compared with the reference
    task automatic tx(input logic [1:0] p, input logic [7:0] ch);
        logic [7:0] c, m;
        logic [9:0] exp_q[$];
        logic       tr;
        tr = cfg[p][1:0] < 2;
        m  = 8'hff >> cfg[p][9:8];
        c  = (tr && ch == 8'h9b) ? 8'h0d : ch;
        if (!(cfg[p][1:0] == sctp_pkg::XL_HEAVY && ch != 8'h9b && (ch < 8'h20 || ch > 8'h7c))) begin
            if (tr) c[7] = 1'b0;
            exp_q.push_back({p, par(cfg[p][5:4], c) & m});
            if (tr && cfg[p][6] && c == 8'h0d) exp_q.push_back({p, par(cfg[p][5:4], 8'h0a) & m});
        end
        @(posedge pclk);
        host_tx_valid <= 1'b1;
        host_tx_port  <= p;
        host_tx_char  <= ch;
        do @(posedge pclk); while (host_tx_ready !== 1'b1);
        host_tx_valid <= 1'b0;
        repeat (2) @(posedge pclk);
        while (host_tx_ready !== 1'b1 || ser_tx_valid !== 1'b0) @(posedge pclk);
        chk("tx count", exp_q.size(), far.got_q.size());
        while (exp_q.size() > 0 && far.got_q.size() > 0)
            chk("tx word", exp_q.pop_front(), far.got_q.pop_front());
        far.got_q.delete();
    endtask : tx

    // Serial word in, host character compared with the reference
    task automatic rx(input logic [1:0] p, input logic [7:0] w);
        logic [7:0] c, m;
        logic       pe;
        m  = 8'hff >> cfg[p][9:8];
        c  = w | ~m;
        pe = (cfg[p][3:2] == sctp_pkg::IP_EVEN) ? ^c : (cfg[p][3:2] == sctp_pkg::IP_ODD) ? ~^c : 1'b0;
        if (cfg[p][3:2] != sctp_pkg::IP_KEEP) c[7] = 1'b0;
        if (cfg[p][1:0] < 2) begin
            c[7] = 1'b0;
            if (c == 8'h0d) c = 8'h9b;
            else if (cfg[p][1:0] == sctp_pkg::XL_HEAVY && (c < 8'h20 || c > 8'h7c)) c = cfg[p][23:16];
        end
        far.put(p, w & m);
        @(posedge pclk);
        chk("rx valid", 1, host_rx_valid);
        chk("rx char", {p, c}, {host_rx_port, host_rx_char});
        chk("rx perr", pe, host_rx_perr);
        if (pe) perr[p] = 1'b1;
    endtask : rx

    task automatic test_done;
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : test_done

    // Watchdog
    initial begin
        repeat (30000) @(posedge pclk);
        fail_count++;
        test_done();
    end

    // Main sequence
    initial begin
        {pclk, psel, penable, pwrite, host_tx_valid, stall, perr} = '0;
        {paddr, pwdata, host_tx_port, host_tx_char, dsr_input, cts_input, carrier_detect_input} = '0;
        rng     = 16'h0008;
        presetn = 1'b0;
        foreach (cfg[p]) cfg[p] = '0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        repeat (2) @(posedge pclk);
        for (int p = 0; p < 4; p++) begin
            apb(1'b0, 8'(4 * p), 32'h0);
            chk("cfg reset", 0, rd);
        end
        $display("test reset done");
        for (int i = 0; i < 8; i++) begin
            cfg[i % 4] = cfgs[i];
            apb(1'b1, 8'(4 * (i % 4)), {8'h00, cfgs[i]});
            for (int k = 0; k < 14; k++) begin
                tx(2'(i), (k < 10) ? chars[k] : rng[7:0]);
                rx(2'(i), (k < 10) ? chars[k] : rng[15:8]);
            end
            $display("test config %0d done", i);
        end
        for (int r = 0; r < 3; r++) begin
            @(posedge pclk);
            {dsr_input, cts_input, carrier_detect_input} <= rng[11:0];
            repeat (4) @(posedge pclk);
            for (int p = 0; p < 4; p++) begin
                logic [2:0] ln;
                ln = {carrier_detect_input[p] | (p != 0), cts_input[p] | (p != 0), dsr_input[p] | (p == 3)};
                apb(1'b0, 8'(4 * p), 32'h0);
                chk("cfg keep", cfg[p], rd);
                cfg[p][12:10] = 3'(r + 5);
                apb(1'b1, 8'(4 * p), {8'h00, cfg[p]});
                apb(1'b0, 8'(8'h10 + 4 * p), 32'h0);
                chk("status", {25'h0, ln, 3'h0, perr[p]}, rd);
                @(posedge pclk);
                chk("lines ok", &(ln | ~cfg[p][12:10]), lines_ok[p]);
                apb(1'b1, 8'(8'h10 + 4 * p), 32'h1);
                perr[p] = 1'b0;
            end
        end
        $display("test status done");
        apb(1'b1, 8'h20, 32'h1);
        apb(1'b0, 8'h10, 32'h0);
        chk("busy status err", 1, er);
        chk("busy status data", 0, rd);
        apb(1'b1, 8'h20, 32'h0);
        apb(1'b0, 8'h10, 32'h0);
        chk("free status err", 0, er);
        apb(1'b0, 8'h40, 32'h0);
        chk("unmapped err", 1, er);
        chk("unmapped data", 0, rd);
        $display("test access done");
        test_done();
    end
endmodule : serial_char_translate_parity_tb
